// ==== rtl/sar_pkg.sv ====
package sar_pkg;
  // result width in bits
  localparam int RESULT_W = 18;
  // system clock period in ns
  localparam int CLK_PERIOD_NS = 40;
  // conversion time bounds in ns
  localparam int T_CONV_MIN_NS = 500;
  localparam int T_CONV_MAX_NS = 8800;
  // least time rounds up, longest rounds down
  localparam int CONV_MIN_CYC = (T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC = T_CONV_MAX_NS / CLK_PERIOD_NS;
  // default conversion length inside the bounds
  localparam int CONV_DEF_CYC = CONV_MAX_CYC;
  // bit counter width
  localparam int CNT_W = 5;
  // conversion counter width
  localparam int CONV_CNT_W = 9;
  // reset values
  localparam logic [17:0] RESULT_RST = 18'h00000;
  // interface modes
  typedef enum logic [1:0] {
    SAR_MODE_CS3 = 2'b00,
    SAR_MODE_CS4 = 2'b01,
    SAR_MODE_DAISY = 2'b10
  } sar_mode_e;
  // sequencing states
  typedef enum logic [1:0] {
    SAR_ST_IDLE = 2'b00,
    SAR_ST_CONV = 2'b01,
    SAR_ST_ACQ = 2'b10
  } sar_state_e;
endpackage

// ==== rtl/sar_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// two flip-flop synchroniser with edge detect on the settled copy
module sar_sync #(
  parameter logic IDLE = 1'b0  // rest level of the pin, so reset leaves no false edge
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  // first stage read only by the second
  logic meta;
  logic settled;
  logic prev;
  // synchroniser chain
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      // start at the rest level: a pin idling high must not look like a rise
      meta <= IDLE;
      settled <= IDLE;
      prev <= IDLE;
    end
    else
    begin
      meta <= i_pin;
      settled <= meta;
      prev <= settled;
    end
  end
  assign o_level = settled;
  assign o_rise = settled & ~prev;
  assign o_fall = ~settled & prev;
endmodule
`default_nettype wire

// ==== rtl/sar_readout.sv ====
`timescale 1ns/1ps
`default_nettype none
module sar_readout #(
  parameter int CONV_CYC = sar_pkg::CONV_DEF_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_convert_start,   // start pin, async
  input wire logic i_serial_in,       // serial-in / select pin, async
  input wire logic i_sclk,            // host serial clock, async
  input wire logic [17:0] i_sample,   // two's complement code from the array
  output logic o_serial_out,
  output logic o_serial_out_en,       // high while the pin is driven
  output logic o_powered,             // converter core powered
  output logic o_sample_hold          // one cycle at sampling instant
);
  // synchronised pins
  logic cs_lvl, cs_rise, cs_fall;
  logic si_lvl, si_rise, si_fall;
  logic ck_fall;
  // sequencing state
  sar_pkg::sar_state_e state;
  sar_pkg::sar_mode_e mode;
  logic [sar_pkg::CONV_CNT_W-1:0] conv_cnt;
  logic [sar_pkg::RESULT_W-1:0] shreg;
  logic [sar_pkg::CNT_W-1:0] bit_cnt;
  logic reading;  // chip-select readout window open

  sar_sync u_cs (.i_clk(i_clk), .i_reset(i_reset), .i_pin(i_convert_start),
    .o_level(cs_lvl), .o_rise(cs_rise), .o_fall(cs_fall));
  // select rests high, so its synchroniser starts high as well
  sar_sync #(.IDLE(1'b1)) u_si (.i_clk(i_clk), .i_reset(i_reset), .i_pin(i_serial_in),
    .o_level(si_lvl), .o_rise(si_rise), .o_fall(si_fall));
  sar_sync u_ck (.i_clk(i_clk), .i_reset(i_reset), .i_pin(i_sclk),
    .o_level(), .o_rise(), .o_fall(ck_fall));

  // conversion done strobe
  logic conv_done;
  assign conv_done = (state == sar_pkg::SAR_ST_CONV)
    && (conv_cnt == sar_pkg::CONV_CNT_W'(CONV_CYC - 1));

  // sequencer: a start edge outside a conversion begins a fresh one;
  // the 3-wire host may drop and restore start mid-conversion, which must not restart it
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state <= sar_pkg::SAR_ST_IDLE;
      mode <= sar_pkg::SAR_MODE_CS3;
      conv_cnt <= '0;
    end
    else if (cs_rise && state != sar_pkg::SAR_ST_CONV)
    begin
      state <= sar_pkg::SAR_ST_CONV;
      conv_cnt <= '0;
      // mode latched from select level at start edge
      if (si_lvl)
      begin
        // 4-wire mode uses select edges; the latch cannot tell, so both run
        mode <= sar_pkg::SAR_MODE_CS3;
      end
      else
      begin
        mode <= sar_pkg::SAR_MODE_DAISY;
      end
    end
    else if (state == sar_pkg::SAR_ST_CONV)
    begin
      // internal count only, blind to start and clock pins
      if (conv_done)
      begin
        state <= sar_pkg::SAR_ST_ACQ;
      end
      else
      begin
        conv_cnt <= conv_cnt + 1'b1;
      end
    end
  end

  // power and sample strobes
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_powered <= 1'b0;
      o_sample_hold <= 1'b0;
    end
    else
    begin
      o_powered <= (state == sar_pkg::SAR_ST_CONV) && !conv_done;
      // only a start edge that really begins a conversion samples
      o_sample_hold <= cs_rise && (state != sar_pkg::SAR_ST_CONV);
    end
  end

  // result register: loaded at conversion end, shifted during readout
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      shreg <= sar_pkg::RESULT_RST;
      bit_cnt <= '0;
      reading <= 1'b0;
    end
    else if (cs_rise && state != sar_pkg::SAR_ST_CONV)
    begin
      reading <= 1'b0;
      bit_cnt <= '0;
    end
    else if (conv_done)
    begin
      shreg <= i_sample;
      bit_cnt <= '0;
    end
    else if (state == sar_pkg::SAR_ST_ACQ)
    begin
      if (mode == sar_pkg::SAR_MODE_DAISY)
      begin
        // daisy: shift in neighbour bit on each falling clock
        if (ck_fall)
        begin
          shreg <= {shreg[sar_pkg::RESULT_W-2:0], si_lvl};
        end
      end
      else if (!reading)
      begin
        // readout opens on a start fall (3-wire) or select fall (4-wire)
        if ((cs_fall || (si_fall && cs_lvl)) && bit_cnt == '0)
        begin
          reading <= 1'b1;
        end
      end
      else if (si_rise && !cs_lvl)
      begin
        reading <= reading;  // select rising with start low is illegal; ignore
      end
      else if (si_rise)
      begin
        reading <= 1'b0;
      end
      else if (ck_fall)
      begin
        // 18th falling edge ends the word
        if (bit_cnt == sar_pkg::CNT_W'(sar_pkg::RESULT_W - 1))
        begin
          reading <= 1'b0;
        end
        shreg <= {shreg[sar_pkg::RESULT_W-2:0], 1'b0};
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end

  // pin drive: readout window, daisy chain, or both-low forced low
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_serial_out <= 1'b0;
      o_serial_out_en <= 1'b0;
    end
    else if (!si_lvl && !cs_lvl)
    begin
      o_serial_out <= 1'b0;
      o_serial_out_en <= 1'b1;
    end
    else if (state == sar_pkg::SAR_ST_ACQ && mode == sar_pkg::SAR_MODE_DAISY && cs_lvl)
    begin
      o_serial_out <= shreg[sar_pkg::RESULT_W-1];
      o_serial_out_en <= 1'b1;
    end
    else if (reading && state == sar_pkg::SAR_ST_ACQ)
    begin
      o_serial_out <= shreg[sar_pkg::RESULT_W-1];
      o_serial_out_en <= 1'b1;
    end
    else
    begin
      // released during conversion and outside a read
      o_serial_out <= 1'b0;
      o_serial_out_en <= 1'b0;
    end
  end

  // assertions
  property p_conv_len;
    @(posedge i_clk) disable iff (i_reset)
    $rose(o_sample_hold) |-> !(state == sar_pkg::SAR_ST_ACQ) [*8];
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion ended too soon");
  property p_rise_release;
    @(posedge i_clk) disable iff (i_reset)
    cs_rise && si_lvl |=> ##1 !o_serial_out_en;
  endproperty
  a_rise_release: assert property (p_rise_release) else $error("output not released");
  property p_both_low;
    @(posedge i_clk) disable iff (i_reset)
    (!si_lvl && !cs_lvl) |=> (o_serial_out_en && !o_serial_out);
  endproperty
  a_both_low: assert property (p_both_low) else $error("output not low");
  property p_load;
    @(posedge i_clk) disable iff (i_reset)
    conv_done && !cs_rise |=> shreg == $past(i_sample);
  endproperty
  a_load: assert property (p_load) else $error("result not loaded");
  property p_powerdown;
    @(posedge i_clk) disable iff (i_reset)
    conv_done |=> ##1 !o_powered;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("not powered down");
  property p_no_early_read;
    @(posedge i_clk) disable iff (i_reset)
    (state == sar_pkg::SAR_ST_CONV) |=> !(o_serial_out_en && si_lvl);
  endproperty
  a_no_early_read: assert property (p_no_early_read) else $error("read during conversion");
  property p_shift;
    @(posedge i_clk) disable iff (i_reset)
    reading && ck_fall && !cs_rise && !si_rise && state == sar_pkg::SAR_ST_ACQ
      |=> shreg[sar_pkg::RESULT_W-1] == $past(shreg[sar_pkg::RESULT_W-2]);
  endproperty
  a_shift: assert property (p_shift) else $error("bit not advanced");
  property p_daisy_shift;
    @(posedge i_clk) disable iff (i_reset)
    mode == sar_pkg::SAR_MODE_DAISY && state == sar_pkg::SAR_ST_ACQ && ck_fall && !cs_rise
      |=> shreg[0] == $past(si_lvl);
  endproperty
  a_daisy_shift: assert property (p_daisy_shift) else $error("daisy input lost");
  c_conv: cover property (@(posedge i_clk) conv_done);
  c_read: cover property (@(posedge i_clk) $fell(reading));
  c_daisy: cover property (@(posedge i_clk) mode == sar_pkg::SAR_MODE_DAISY && ck_fall);
endmodule
`default_nettype wire

// ==== sim/sar_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// host model: drives start, select and serial clock, captures data
module sar_host (
  input wire logic i_clk,
  input wire logic i_serial_out,
  input wire logic i_serial_out_en,
  output logic o_convert_start,
  output logic o_serial_in,
  output logic o_sclk
);
  // idle pins: start low, select high, so the output is never forced on
  initial
  begin
    o_convert_start = 1'b0;
    o_serial_in = 1'b1;
    o_sclk = 1'b0;
  end
  // wait n system clocks, always ending on a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // both control pins change together, so they never pass through a both-low state
  task automatic pins(input logic st, input logic sl);
    o_convert_start = st;
    o_serial_in = sl;
  endtask
  // one frame of n clock falls, half period four clocks
  task automatic shift(input int n, input logic daisy, input logic [17:0] feed,
    output logic [35:0] q, output logic en_all);
    en_all = 1'b1;
    q = '0;
    for (int i = 0; i < n; i++)
    begin
      cyc(4);
      // capture just before the rise, the bit has settled since the last fall
      q = {q[34:0], i_serial_out};
      en_all = en_all & i_serial_out_en;
      o_sclk = 1'b1;
      // chain input changes while the clock is high, steady at the fall
      if (daisy)
        o_serial_in = (i < 18) ? feed[17 - i] : 1'b0;
      cyc(4);
      o_sclk = 1'b0; // clock rests low between frames
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // short conversion keeps the run brief, still above the minimum time
  localparam int CONV = 20;
  logic clk;
  logic reset;
  logic [17:0] sample; // code handed to the converter
  logic dout;
  logic dout_en;
  logic powered;
  logic sample_hold; // one-cycle sampling strobe
  logic [35:0] q; // captured frame
  logic en_all; // output enable seen at every capture
  int n_fail = 0;
  int tests_run = 0;
  wire start;
  wire sel;
  wire sclk;
  sar_readout #(.CONV_CYC(CONV)) u_dut (.i_clk(clk), .i_reset(reset),
    .i_convert_start(start), .i_serial_in(sel), .i_sclk(sclk), .i_sample(sample),
    .o_serial_out(dout), .o_serial_out_en(dout_en), .o_powered(powered),
    .o_sample_hold(sample_hold));
  sar_host u_host (.i_clk(clk), .i_serial_out(dout), .i_serial_out_en(dout_en),
    .o_convert_start(start), .o_serial_in(sel), .o_sclk(sclk));
  // 25 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // chip-select conversion; four picks the select pin as opener, n bits read
  task automatic t_cs(input logic four, input int n, input logic [17:0] v);
    sample = v;
    u_host.pins(1'b0, 1'b1);
    u_host.cyc(8);
    u_host.pins(1'b1, 1'b1); // select high at the start rise
    u_host.cyc(3);
    check(sample_hold, 1'b1);
    u_host.cyc(4);
    check(dout_en, 1'b0);
    check(powered, 1'b1);
    u_host.pins(four, ~four); // early opener while converting
    u_host.cyc(4);
    check(dout_en, 1'b0);
    u_host.pins(1'b1, 1'b1); // back high before the minimum time
    u_host.cyc(3);
    check(sample_hold, 1'b0);
    u_host.cyc(CONV - 3);
    check(powered, 1'b0);
    u_host.pins(four, ~four); // opens with the output released
    u_host.shift(n, 1'b0, 18'h00000, q, en_all);
    check(q, 36'(v) >> (18 - n));
    check(en_all, 1'b1);
    // a short frame ends by raising the opener
    u_host.pins(1'b1, 1'b1);
    u_host.cyc(6);
    check(dout_en, 1'b0);
    // in 3-wire runs the start rise here begins a conversion; let it finish before the next scenario
    u_host.cyc(CONV + 8);
    $display("test chip-select done, four %0d bits %0d", four, n);
  endtask
  // one device in a chain, the testbench stands in for the previous one
  task automatic t_daisy(input logic [17:0] v, input logic [17:0] feed);
    sample = v;
    u_host.pins(1'b0, 1'b0);
    u_host.cyc(8);
    check({dout_en, dout}, 2'b10);
    u_host.pins(1'b1, 1'b0); // select low at the start rise
    u_host.cyc(CONV + 10);
    check({dout_en, dout}, {1'b1, v[17]});
    u_host.shift(36, 1'b1, feed, q, en_all);
    check(q, {v, feed});
    check(en_all, 1'b1);
    u_host.pins(1'b0, 1'b1);
    u_host.cyc(8);
    $display("test daisy-chain done");
  endtask
  initial
  begin
    reset = 1'b1;
    sample = 18'h00000;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    u_host.cyc(2);
    t_cs(1'b0, 18, 18'h2a5c3);
    t_cs(1'b0, 5, 18'h15a3c);
    t_cs(1'b1, 18, 18'h3f00f);
    t_cs(1'b1, 5, 18'h0c3a5);
    t_daisy(18'h20001, 18'h1b6d9);
    summarize();
  end
  // cuts a hang short
  initial
  begin
    #400000;
    n_fail++;
    $display("watchdog expired");
    summarize();
  end
endmodule
`default_nettype wire
